// [hw/ccio_consts.vh]
// Purpose: constants for the card configuration and I/O port block
// Assumes: attribute offsets are byte addresses on the host bus
// Notes:   bit positions are within the 8-bit register value
`ifndef CCIO_CONSTS_VH
`define CCIO_CONSTS_VH
`define CCIO_OFS_CFG_OPT      11'h200
`define CCIO_OFS_CFG_STATUS   11'h202
`define CCIO_OFS_PIN_REPL     11'h204
`define CCIO_OFS_SOCK_COPY    11'h206
`define CCIO_CS_SUMMARY_BIT   7
`define CCIO_CS_CHANGE_SIGNAL_ENABLE_BIT    6
`define CCIO_CS_IO8_BIT       5
`define CCIO_CS_PWRSAVE_BIT   2
`define CCIO_CS_INT_BIT       1
`define CCIO_PR_RDYCHG_BIT    5
`define CCIO_PR_WLCHG_BIT     4
`define CCIO_PR_RDYLIVE_BIT   1
`define CCIO_PR_WLLIVE_BIT    0
`define CCIO_SC_DRIVE_BIT     4
`define CCIO_CFG_INDEX_RESET  6'h00
`define CCIO_PWR_SETTLE_NS    1000
`define CCIO_CLK_NS           100
`define CCIO_PWR_SETTLE_CYC   ((`CCIO_PWR_SETTLE_NS + `CCIO_CLK_NS - 1) / `CCIO_CLK_NS)
`define CCIO_IDLE_CYC         4000
`endif

// [hw/ccio_power_ctrl.v]
// Purpose: power state sequencing with busy indication
// Assumes: one settle period per requested state change
// Notes:   idle timer drops to power save, a command wakes it
`timescale 1ns/10ps
`include "ccio_consts.vh"
module ccio_power_ctrl #(
  parameter SETTLE_CYC = `CCIO_PWR_SETTLE_CYC,
  parameter IDLE_CYC   = `CCIO_IDLE_CYC
)(
  input  wire mclk_in,
  input  wire reset_in,
  input  wire power_save_request_in,
  input  wire command_in,
  output reg  powered_down_out,
  output reg  busy_out
);
  reg        req_prev_q;
  reg [15:0] settle_q;
  reg [15:0] idle_q;
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      req_prev_q       <= 1'b0;
      settle_q         <= 16'h0000;
      idle_q           <= 16'h0000;
      powered_down_out <= 1'b0;
      busy_out         <= 1'b0;
    end
    else
    begin
      req_prev_q <= power_save_request_in;
      if (power_save_request_in != req_prev_q)
      begin
        busy_out <= 1'b1;
        settle_q <= SETTLE_CYC[15:0];
      end
      else if (settle_q > 16'h0001)
        settle_q <= settle_q - 16'h0001;
      else if (busy_out)
      begin
        busy_out         <= 1'b0;
        settle_q         <= 16'h0000;
        powered_down_out <= req_prev_q;
      end
      else if (command_in)
      begin
        idle_q           <= 16'h0000;
        powered_down_out <= req_prev_q;
      end
      else if (idle_q == IDLE_CYC[15:0] - 16'h0001)
        powered_down_out <= 1'b1;
      else
        idle_q <= idle_q + 16'h0001;
    end
  end
endmodule // ccio_power_ctrl

// [hw/ccio_lane_steer.v]
// Purpose: byte lane steering for I/O transfers
// Assumes: internal side is one 16-bit word, even byte low
// Notes:   lane output enables active low, write byte enables active high, one per byte lane
`timescale 1ns/10ps
module ccio_lane_steer (
  input  wire        low_byte_select_n_in,
  input  wire        high_byte_select_n_in,
  input  wire        addr0_in,
  input  wire [15:0] rd_word_in,
  input  wire [15:0] bus_data_in,
  output reg  [15:0] bus_data_out,
  output reg         lo_lane_oe_n_out,
  output reg         hi_lane_oe_n_out,
  output reg  [15:0] wr_word_out,
  output reg  [1:0]  wr_byte_en_out
);
  always @*
  begin
    bus_data_out     = 16'h0000;
    lo_lane_oe_n_out = 1'b1;
    hi_lane_oe_n_out = 1'b1;
    wr_word_out      = 16'h0000;
    wr_byte_en_out   = 2'b00;
    case ({high_byte_select_n_in, low_byte_select_n_in})
      2'b10:
      begin
        lo_lane_oe_n_out   = 1'b0;
        bus_data_out[7:0]  = addr0_in ? rd_word_in[15:8] : rd_word_in[7:0];
        wr_word_out        = {bus_data_in[7:0], bus_data_in[7:0]};
        wr_byte_en_out     = addr0_in ? 2'b10 : 2'b01;
      end
      2'b00:
      begin
        lo_lane_oe_n_out = 1'b0;
        hi_lane_oe_n_out = 1'b0;
        bus_data_out     = rd_word_in;
        wr_word_out      = bus_data_in;
        wr_byte_en_out   = 2'b11;
      end
      2'b01:
      begin
        hi_lane_oe_n_out   = 1'b0;
        bus_data_out[15:8] = rd_word_in[15:8];
        wr_word_out        = {bus_data_in[15:8], 8'h00};
        wr_byte_en_out     = 2'b10;
      end
      default:
      begin
        bus_data_out = 16'h0000;
      end
    endcase
  end
endmodule // ccio_lane_steer

// [hw/ccio_port.v]
// Purpose: card configuration registers and I/O lane steering
// Assumes: host strobes synchronous to mclk_in; one access per strobe
// Notes:   lane enables low while driving; I/O word goes to core ports
`timescale 1ns/10ps
`include "ccio_consts.vh"
module ccio_port #(
  parameter SETTLE_CYC = `CCIO_PWR_SETTLE_CYC,
  parameter IDLE_CYC   = `CCIO_IDLE_CYC
)(
  input  wire        mclk_in,
  input  wire        reset_in,
  input  wire        soft_reset_in,
  input  wire        low_byte_select_n_in,
  input  wire        high_byte_select_n_in,
  input  wire        attribute_select_n_in,
  input  wire        output_enable_n_in,
  input  wire        write_enable_n_in,
  input  wire        io_read_strobe_n_in,
  input  wire        io_write_strobe_n_in,
  input  wire [10:0] addr_in,
  input  wire [15:0] data_in,
  input  wire        io_decode_hit_in,
  input  wire [15:0] io_rd_word_in,
  input  wire        core_irq_in,
  input  wire        irq_disable_bit_in,
  input  wire        core_command_in,
  input  wire        core_busy_in,
  output reg  [15:0] data_out,
  output reg         lo_lane_oe_n_out,
  output reg         hi_lane_oe_n_out,
  output reg         wide_port_pin_n_out,
  output reg         status_change_pin_n_out,
  output reg         ready_busy_line_out,
  output reg  [5:0]  config_index_out,
  output reg         drive_number_out,
  output reg         powered_down_out,
  output reg         io_wr_strobe_out,
  output reg  [15:0] io_wr_word_out,
  output reg  [1:0]  io_wr_byte_en_out
);
  reg        change_signal_enable_q;
  reg        eight_bit_io_request_q;
  reg        power_save_request_q;
  reg        ready_change_latch_q;
  reg        write_lock_change_latch_q;
  reg        live_ready_prev_q;
  reg        io_write_strobe_n_prev_q;
  reg        attr_wr_prev_q;
  wire       pwr_busy;
  wire       pwr_down;
  wire       live_ready_state;
  wire       live_write_lock;
  wire       io_mode;
  wire       summary;
  wire       int_view;
  wire       any_reset;
  wire       card_sel;
  wire       attr_rd;
  wire       attr_wr;
  wire       attr_wr_edge;
  wire       io_rd;
  wire       io_wr;
  wire       io_hit;
  wire       attr_rd_ok;
  wire [7:0] cs_read;
  wire [7:0] pr_read;
  wire [7:0] sc_read;
  wire [15:0] steer_data;
  wire        steer_lo_oe_n;
  wire        steer_hi_oe_n;
  wire [15:0] steer_wr_word;
  wire [1:0]  steer_wr_be;
  reg  [7:0]  attr_byte;
  reg         attr_hit;
  wire        rdy_chg_wr;
  wire        wl_chg_wr;

  ccio_power_ctrl #(
    .SETTLE_CYC (SETTLE_CYC),
    .IDLE_CYC   (IDLE_CYC)
  ) u_power (
    .mclk_in               (mclk_in),
    .reset_in              (any_reset),
    .power_save_request_in (power_save_request_q),
    .command_in            (core_command_in),
    .powered_down_out      (pwr_down),
    .busy_out              (pwr_busy)
  );

  ccio_lane_steer u_steer (
    .low_byte_select_n_in  (low_byte_select_n_in),
    .high_byte_select_n_in (high_byte_select_n_in),
    .addr0_in              (addr_in[0]),
    .rd_word_in            (io_rd_word_in),
    .bus_data_in           (data_in),
    .bus_data_out          (steer_data),
    .lo_lane_oe_n_out      (steer_lo_oe_n),
    .hi_lane_oe_n_out      (steer_hi_oe_n),
    .wr_word_out           (steer_wr_word),
    .wr_byte_en_out        (steer_wr_be)
  );

  assign any_reset        = reset_in | soft_reset_in;
  assign card_sel         = ~low_byte_select_n_in | ~high_byte_select_n_in;
  assign io_mode          = (config_index_out != 6'h00);
  assign live_ready_state = ~(pwr_busy | core_busy_in);
  assign live_write_lock  = 1'b0;
  assign summary          = ready_change_latch_q | write_lock_change_latch_q;
  assign int_view         = core_irq_in & ~irq_disable_bit_in;
  assign attr_rd  = ~low_byte_select_n_in & ~attribute_select_n_in & ~output_enable_n_in & write_enable_n_in;
  assign attr_wr  = ~low_byte_select_n_in & ~attribute_select_n_in & output_enable_n_in & ~write_enable_n_in;
  assign attr_wr_edge = attr_wr & ~attr_wr_prev_q;
  // I/O answers only in I/O mode
  assign io_hit   = card_sel & ~attribute_select_n_in & io_mode & io_decode_hit_in;
  assign io_rd    = io_hit & ~io_read_strobe_n_in & io_write_strobe_n_in;
  assign io_wr    = io_hit & io_read_strobe_n_in & ~io_write_strobe_n_in;
  // odd and unmapped attribute reads stay off the bus
  assign attr_rd_ok = attr_rd & attr_hit & ~addr_in[0];

  assign cs_read = {summary, change_signal_enable_q, eight_bit_io_request_q, 2'b00,
                    power_save_request_q, int_view, 1'b0};
  assign pr_read = {2'b00, ready_change_latch_q, write_lock_change_latch_q, 2'b11,
                    live_ready_state, live_write_lock};
  assign sc_read = {3'b000, drive_number_out, 4'h0};

  always @*
  begin
    attr_hit  = 1'b1;
    case (addr_in)
      `CCIO_OFS_CFG_OPT:    attr_byte = {2'b00, config_index_out};
      `CCIO_OFS_CFG_STATUS: attr_byte = cs_read;
      `CCIO_OFS_PIN_REPL:   attr_byte = pr_read;
      `CCIO_OFS_SOCK_COPY:  attr_byte = sc_read;
      default:
      begin
        attr_byte = 8'h00;
        attr_hit  = 1'b0;
      end
    endcase
  end

  assign rdy_chg_wr = attr_wr_edge & (addr_in == `CCIO_OFS_PIN_REPL) & data_in[`CCIO_PR_RDYLIVE_BIT];
  assign wl_chg_wr  = attr_wr_edge & (addr_in == `CCIO_OFS_PIN_REPL) & data_in[`CCIO_PR_WLLIVE_BIT];

  always @(posedge mclk_in)
  begin
    if (any_reset)
    begin
      change_signal_enable_q    <= 1'b0;
      eight_bit_io_request_q    <= 1'b0;
      power_save_request_q      <= 1'b0;
      ready_change_latch_q      <= 1'b0;
      write_lock_change_latch_q <= 1'b0;
      config_index_out          <= `CCIO_CFG_INDEX_RESET;
      drive_number_out          <= 1'b0;
      live_ready_prev_q         <= 1'b1;
      attr_wr_prev_q            <= 1'b0;
    end
    else
    begin
      live_ready_prev_q <= live_ready_state;
      attr_wr_prev_q    <= attr_wr;
      if (attr_wr_edge)
      begin
        case (addr_in)
          `CCIO_OFS_CFG_OPT:
            config_index_out <= data_in[5:0];
          `CCIO_OFS_CFG_STATUS:
          begin
            change_signal_enable_q <= data_in[`CCIO_CS_CHANGE_SIGNAL_ENABLE_BIT];
            eight_bit_io_request_q <= data_in[`CCIO_CS_IO8_BIT];
            power_save_request_q   <= data_in[`CCIO_CS_PWRSAVE_BIT];
          end
          `CCIO_OFS_SOCK_COPY:
            drive_number_out <= data_in[`CCIO_SC_DRIVE_BIT];
          default:
            drive_number_out <= drive_number_out;
        endcase
      end
      // set on ready change wins over host write
      if (live_ready_state != live_ready_prev_q)
        ready_change_latch_q <= 1'b1;
      else if (rdy_chg_wr)
        ready_change_latch_q <= data_in[`CCIO_PR_RDYCHG_BIT];
      // lock never changes, host write only
      if (wl_chg_wr)
        write_lock_change_latch_q <= data_in[`CCIO_PR_WLCHG_BIT];
    end
  end

  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      data_out                <= 16'h0000;
      lo_lane_oe_n_out        <= 1'b1;
      hi_lane_oe_n_out        <= 1'b1;
    end
    else
    begin
      if (attr_rd_ok)
      begin
        data_out         <= {8'h00, attr_byte};
        lo_lane_oe_n_out <= 1'b0;
        hi_lane_oe_n_out <= 1'b1;
      end
      else if (io_rd)
      begin
        data_out         <= steer_data;
        lo_lane_oe_n_out <= steer_lo_oe_n;
        hi_lane_oe_n_out <= steer_hi_oe_n;
      end
      else
      begin
        data_out         <= 16'h0000;
        lo_lane_oe_n_out <= 1'b1;
        hi_lane_oe_n_out <= 1'b1;
      end
    end
  end

  // host-visible status pins
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      wide_port_pin_n_out     <= 1'b1;
      status_change_pin_n_out <= 1'b1;
      ready_busy_line_out     <= 1'b0;
      powered_down_out        <= 1'b0;
    end
    else
    begin
      powered_down_out <= pwr_down;
      ready_busy_line_out <= live_ready_state;
      status_change_pin_n_out <= ~(io_mode & summary & change_signal_enable_q);
      wide_port_pin_n_out <= ~io_hit;
    end
  end

  // one core write per strobe, first cycle only
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      io_wr_strobe_out  <= 1'b0;
      io_wr_word_out    <= 16'h0000;
      io_wr_byte_en_out <= 2'b00;
      io_write_strobe_n_prev_q       <= 1'b0;
    end
    else
    begin
      io_write_strobe_n_prev_q      <= io_wr;
      io_wr_strobe_out <= io_wr & ~io_write_strobe_n_prev_q;
      if (io_wr & ~io_write_strobe_n_prev_q)
      begin
        io_wr_word_out    <= steer_wr_word;
        io_wr_byte_en_out <= steer_wr_be;
      end
    end
  end
endmodule // ccio_port

// [tb/ccio_port_assertions.sv]
// Purpose: port-level checker for the card configuration and I/O port
// Assumes: registered outputs answer one edge after the request
// Notes:   bound into every ccio_port instance
`timescale 1ns/10ps
module ccio_port_chk #(
  parameter SETTLE_CYC = 10,
  parameter IDLE_CYC   = 4000
)(
  input wire        mclk_in,
  input wire        reset_in,
  input wire        soft_reset_in,
  input wire        low_byte_select_n_in,
  input wire        high_byte_select_n_in,
  input wire        attribute_select_n_in,
  input wire        output_enable_n_in,
  input wire        write_enable_n_in,
  input wire        io_read_strobe_n_in,
  input wire        io_write_strobe_n_in,
  input wire [10:0] addr_in,
  input wire [15:0] data_in,
  input wire        io_decode_hit_in,
  input wire [15:0] io_rd_word_in,
  input wire [15:0] data_out,
  input wire        lo_lane_oe_n_out,
  input wire        hi_lane_oe_n_out,
  input wire        wide_port_pin_n_out,
  input wire        status_change_pin_n_out,
  input wire [5:0]  config_index_out,
  input wire        drive_number_out,
  input wire        powered_down_out,
  input wire        io_wr_strobe_out,
  input wire [15:0] io_wr_word_out,
  input wire [1:0]  io_wr_byte_en_out
);
  wire lo   = !low_byte_select_n_in;
  wire hi   = !high_byte_select_n_in;
  wire io   = (lo || hi) && !attribute_select_n_in && io_decode_hit_in && config_index_out != 6'h00;
  wire io_read_strobe_n = io && !io_read_strobe_n_in;
  wire ard  = lo && !attribute_select_n_in && !output_enable_n_in && write_enable_n_in;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in || soft_reset_in);
  io_wide_a: assert property (io_read_strobe_n |=> !wide_port_pin_n_out)
    else $error("wide port pin not asserted on i/o read");
  mem_wide_a: assert property (config_index_out == 6'h00 |=> wide_port_pin_n_out)
    else $error("wide port pin asserted in memory mode");
  mem_chg_a: assert property (config_index_out == 6'h00 |=> status_change_pin_n_out)
    else $error("status change pin low in memory mode");
  word_rd_a: assert property (io_read_strobe_n && lo && hi |=> !lo_lane_oe_n_out && !hi_lane_oe_n_out
    && data_out == $past(io_rd_word_in)) else $error("word read lanes wrong");
  byte_rd_a: assert property (io_read_strobe_n && lo && !hi |=> !lo_lane_oe_n_out && hi_lane_oe_n_out
    && data_out[7:0] == ($past(addr_in[0]) ? $past(io_rd_word_in[15:8]) : $past(io_rd_word_in[7:0])))
    else $error("byte read lanes wrong");
  high_rd_a: assert property (io_read_strobe_n && !lo && hi |=> lo_lane_oe_n_out && !hi_lane_oe_n_out
    && data_out[15:8] == $past(io_rd_word_in[15:8])) else $error("odd byte read lanes wrong");
  word_wr_a: assert property (io && lo && hi && $fell(io_write_strobe_n_in) |=> io_wr_strobe_out
    && io_wr_byte_en_out == 2'h3 && io_wr_word_out == $past(data_in)) else $error("word write wrong");
  cfg_rd_a: assert property (ard && addr_in == 11'h202 |=> !lo_lane_oe_n_out
    && data_out[4:3] == 2'h0 && !data_out[0]) else $error("status register fixed bits wrong");
  pin_rd_a: assert property (ard && addr_in == 11'h204 |=> data_out[7:6] == 2'h0
    && data_out[3:2] == 2'h3 && !data_out[0]) else $error("pin register fixed bits wrong");
  sock_rd_a: assert property (ard && addr_in == 11'h206 |=>
    data_out[7:0] == {3'h0, drive_number_out, 4'h0}) else $error("socket register read wrong");
  cover property (io_read_strobe_n && lo && hi);
  cover property (!status_change_pin_n_out);
  cover property ($rose(powered_down_out));
endmodule // ccio_port_chk
bind ccio_port ccio_port_chk #(.SETTLE_CYC(SETTLE_CYC), .IDLE_CYC(IDLE_CYC)) chk_u (.*);

// [tb/ccio_host_model.sv]
// Purpose: host socket model running attribute and I/O cycles
// Assumes: signals change on the falling edge of mclk_in
// Notes:   released data lines carry the inverse of the last value
`timescale 1ns/10ps
module ccio_host_model (
  input  wire        mclk_in,
  input  wire [15:0] data_in,
  output reg  [6:0]  strobe_n_out,
  output reg  [10:0] addr_out,
  output reg  [15:0] data_out
);
  // strobe_n_out: hi sel, lo sel, attr, oe, we, ior, iow
  initial
  begin
    strobe_n_out = 7'h7F;
    addr_out = 11'h000;
    data_out = 16'h0000;
  end
  // kind 0 attr write, 1 attr read, 2 io write, 3 io read
  task acc(input [1:0] kind, input [1:0] sel_n, input [10:0] a, input [15:0] d, output [15:0] rd);
  begin
    @(negedge mclk_in);
    addr_out = a;
    data_out = d;
    strobe_n_out = {sel_n, 1'b0, kind != 2'h1, kind != 2'h0, kind != 2'h3, kind != 2'h2};
    @(negedge mclk_in);
    rd = data_in;
    strobe_n_out = 7'h7F;
    data_out = ~d;
    // idle gap between accesses
    @(negedge mclk_in);
  end
  endtask
endmodule // ccio_host_model

// [tb/tb_top.sv]
// Purpose: self-checking bench for the card configuration and I/O port
// Assumes: short idle count (20) and the default settle count (10) set at the instance
// Notes:   undriven lanes read back what the host last put there
`timescale 1ns/10ps
module tb_top;
  localparam [11:0] MODE = 12'h942;
  localparam [63:0] REXP = 64'hFF5A_FFA5_A55A_A5FF;
  localparam [63:0] WEXP = 64'h0034_3400_1234_1200;
  localparam [7:0]  BEXP = 8'h6E;
  reg         mclk_in, reset_in, soft_reset_in, io_decode_hit_in, core_irq_in;
  reg         irq_disable_bit_in, core_command_in, core_busy_in, awake;
  reg  [15:0] io_rd_word_in, rd;
  reg  [3:0]  cnt = 4'h0;
  integer     i, mismatches, checks_done;
  wire        low_byte_select_n_in, high_byte_select_n_in, attribute_select_n_in, output_enable_n_in;
  wire        write_enable_n_in, io_read_strobe_n_in, io_write_strobe_n_in, lo_lane_oe_n_out;
  wire        hi_lane_oe_n_out, wide_port_pin_n_out, status_change_pin_n_out, ready_busy_line_out;
  wire        drive_number_out, powered_down_out, io_wr_strobe_out;
  wire [1:0]  io_wr_byte_en_out;
  wire [5:0]  config_index_out;
  wire [10:0] addr_in;
  wire [15:0] data_out, io_wr_word_out, hdata;
  wire [15:0] data_in = {hi_lane_oe_n_out ? hdata[15:8] : data_out[15:8],
                         lo_lane_oe_n_out ? hdata[7:0] : data_out[7:0]};
  ccio_port #(.SETTLE_CYC(10), .IDLE_CYC(20)) dut_u (.*);
  ccio_host_model host_u (
    .mclk_in      (mclk_in),
    .data_in      (data_in),
    .strobe_n_out ({high_byte_select_n_in, low_byte_select_n_in, attribute_select_n_in, output_enable_n_in,
                    write_enable_n_in, io_read_strobe_n_in, io_write_strobe_n_in}),
    .addr_out     (addr_in),
    .data_out     (hdata)
  );
  initial
  begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  // periodic commands keep the card awake
  always @(negedge mclk_in)
  begin
    cnt <= cnt + 4'h1;
    core_command_in <= awake && cnt == 4'h0;
  end
  task chk(input [15:0] got, input [15:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task aw(input [10:0] a, input [7:0] d);
    host_u.acc(2'h0, 2'h2, a, {8'h00, d}, rd);
  endtask
  task ar(input [10:0] a, input [7:0] e);
  begin
    host_u.acc(2'h1, 2'h2, a, 16'h0000, rd);
    chk({8'h00, rd[7:0]}, {8'h00, e});
  end
  endtask
  task settle(input e);
  begin
    for (i = 0; i < 80 && (powered_down_out !== e || ready_busy_line_out !== 1'b1); i = i + 1)
      @(negedge mclk_in);
    chk({15'h0000, powered_down_out}, {15'h0000, e});
    chk({15'h0000, ready_busy_line_out}, 16'h0001);
  end
  endtask
  task final_report;
  begin
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #2000000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial
  begin
    {reset_in, soft_reset_in, io_decode_hit_in, core_irq_in, irq_disable_bit_in} = 5'h14;
    {core_busy_in, awake} = 2'h1;
    io_rd_word_in = 16'hA55A;
    mismatches = 0;
    checks_done = 0;
    repeat (16) @(negedge mclk_in);
    reset_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    aw(11'h204, 8'h02);
    ar(11'h204, 8'h0E);
    ar(11'h202, 8'h00);
    aw(11'h204, 8'h20);
    ar(11'h204, 8'h0E);
    aw(11'h204, 8'h22);
    ar(11'h204, 8'h2E);
    ar(11'h202, 8'h80);
    aw(11'h204, 8'h11);
    ar(11'h204, 8'h3E);
    aw(11'h204, 8'h03);
    ar(11'h202, 8'h00);
    core_busy_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    ar(11'h204, 8'h2C);
    core_busy_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    ar(11'h204, 8'h2E);
    aw(11'h206, 8'h1F);
    ar(11'h206, 8'h10);
    chk({15'h0000, drive_number_out}, 16'h0001);
    aw(11'h202, 8'h40);
    chk({15'h0000, status_change_pin_n_out}, 16'h0001);
    aw(11'h200, 8'h01);
    chk({15'h0000, status_change_pin_n_out}, 16'h0000);
    aw(11'h202, 8'h23);
    ar(11'h202, 8'hA0);
    chk({15'h0000, status_change_pin_n_out}, 16'h0001);
    core_irq_in = 1'b1;
    ar(11'h202, 8'hA2);
    irq_disable_bit_in = 1'b1;
    ar(11'h202, 8'hA0);
    {core_irq_in, irq_disable_bit_in} = 2'h0;
    // byte modes: low even, low odd, word, high only
    for (i = 0; i < 4; i = i + 1)
    begin
      host_u.acc(2'h3, MODE[11-3*i -: 2], {10'h000, MODE[9-3*i]}, 16'hFFFF, rd);
      chk(rd, REXP[63-16*i -: 16]);
      host_u.acc(2'h2, MODE[11-3*i -: 2], {10'h000, MODE[9-3*i]}, 16'h1234, rd);
      chk({14'h0000, io_wr_byte_en_out}, {14'h0000, BEXP[7-2*i -: 2]});
      chk(io_wr_word_out & {{8{io_wr_byte_en_out[1]}}, {8{io_wr_byte_en_out[0]}}}, WEXP[63-16*i -: 16]);
    end
    aw(11'h200, 8'h00);
    host_u.acc(2'h3, 2'h0, 11'h000, 16'hFFFF, rd);
    chk(rd, 16'hFFFF);
    aw(11'h202, 8'h04);
    @(negedge mclk_in);
    chk({15'h0000, ready_busy_line_out}, 16'h0000);
    settle(1'b1);
    aw(11'h202, 8'h00);
    @(negedge mclk_in);
    chk({15'h0000, ready_busy_line_out}, 16'h0000);
    settle(1'b0);
    awake = 1'b0;
    settle(1'b1);
    awake = 1'b1;
    settle(1'b0);
    aw(11'h200, 8'h01);
    soft_reset_in = 1'b1;
    @(negedge mclk_in);
    soft_reset_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    chk({9'h000, drive_number_out, config_index_out}, 16'h0000);
    final_report;
  end
endmodule // tb_top
